// [inc/cssg_defines.svh]
`ifndef CSSG_DEFINES_SVH
`define CSSG_DEFINES_SVH

// register width shared by every register of the group
`define CSSG_REG_W        16

// condition bit positions
`define CSSG_BIT_ACTIVE   0
`define CSSG_BIT_REGISTER 1
`define CSSG_BIT_AUTH     2
`define CSSG_BIT_PAGE     3
`define CSSG_BIT_ACCESS   4
`define CSSG_BIT_CONNECT  5
`define CSSG_BIT_RINGING  6
`define CSSG_BIT_TOP      15

// bits that carry no call-state condition, 15 included
`define CSSG_UNUSED_MASK  16'hFF80

// reset values
`define CSSG_RST_ZERO     16'h0000
`define CSSG_RST_RISE     16'hFFFF
`define CSSG_RST_FALL     16'h0000
`define CSSG_RST_ENABLE   16'h0000

`endif

// [inc/cssg_pkg.sv]
`default_nettype none

package cssg_pkg;

  // which register a query or setting addresses
  typedef enum logic [2:0] {
    CSSG_SEL_COND   = 3'b000,
    CSSG_SEL_RISE   = 3'b001,
    CSSG_SEL_FALL   = 3'b010,
    CSSG_SEL_EVENT  = 3'b011,
    CSSG_SEL_ENABLE = 3'b100
  } cssg_sel_type;

  // progress of a base-originated call toward ringing
  typedef enum logic [1:0] {
    CSSG_RING_IDLE   = 2'b00,
    CSSG_RING_ARMED  = 2'b01,
    CSSG_RING_ACCESS = 2'b10,
    CSSG_RING_ON     = 2'b11
  } cssg_ring_type;

endpackage : cssg_pkg

`default_nettype wire

// [rtl/cssg_ring_tracker.sv]
`default_nettype none

module cssg_ring_tracker (
  input  wire logic clk_sys,
  input  wire logic nrst,
  input  wire logic bs_call_attempt,
  input  wire logic ms_answer,
  input  wire logic ind_access,
  output logic      ringing
);

  cssg_pkg::cssg_ring_type state_reg;
  cssg_pkg::cssg_ring_type state_next;

  // ringing waits until the call has passed through access and left it
  always_comb
  begin
    state_next = state_reg;
    unique case (state_reg)
      cssg_pkg::CSSG_RING_IDLE:
        if (bs_call_attempt)
          state_next = cssg_pkg::CSSG_RING_ARMED;
      cssg_pkg::CSSG_RING_ARMED:
        if (ind_access)
          state_next = cssg_pkg::CSSG_RING_ACCESS;
      cssg_pkg::CSSG_RING_ACCESS:
        if (!ind_access)
          state_next = cssg_pkg::CSSG_RING_ON; // see R4
      cssg_pkg::CSSG_RING_ON:
        state_next = cssg_pkg::CSSG_RING_ON;
    endcase
    // answering always ends ringing, even mid-sequence
    if (ms_answer)
      state_next = cssg_pkg::CSSG_RING_IDLE; // see R5
  end

  always_ff @(posedge clk_sys)
  begin
    if (!nrst)
      state_reg <= cssg_pkg::CSSG_RING_IDLE;
    else
      state_reg <= state_next;
  end

  assign ringing = (state_reg == cssg_pkg::CSSG_RING_ON);

  property p_ring_after_access;
    @(posedge clk_sys) disable iff (!nrst)
    $rose(ringing) |-> $past(state_reg == cssg_pkg::CSSG_RING_ACCESS) && !$past(ind_access);
  endproperty
  a_ring_after_access: assert property (p_ring_after_access) // see R4
    else $error("ringing rose without passing access");

  property p_answer_stops_ring;
    @(posedge clk_sys) disable iff (!nrst)
    ms_answer |=> !ringing;
  endproperty
  a_answer_stops_ring: assert property (p_answer_stops_ring) // see R5
    else $error("ringing survived an answer");

endmodule : cssg_ring_tracker

`default_nettype wire

// [rtl/cssg_status_group.sv]
// Function
// R1: every group register is sixteen bits wide
// R2: condition, two filters, event, enable, summary
// R3: bit 15 zero; bits 7-14 unused
// R4: ringing sets after originated call passes access
// R5: ringing clears when mobile answers
// R6: bit 5 follows connect indicator
// R7: bit 4 follows access indicator
// R8: bit 3 follows page indicator
// R9: bit 2 follows authenticating
// R10: bit 1 follows register indicator
// R11: bit 0 follows active indicator
// R12: event register cleared by read or clear-status
// R13: filtered condition edges latch event bits
// R14: summary is OR of event AND enable
`include "cssg_defines.svh"
`default_nettype none

module cssg_status_group (
  input  wire logic                          clk_sys,
  input  wire logic                          nrst,
  // call subsystem indicators, levels
  input  wire logic                          ind_active,
  input  wire logic                          ind_register,
  input  wire logic                          ind_auth,
  input  wire logic                          ind_page,
  input  wire logic                          ind_access,
  input  wire logic                          ind_connect,
  // call events, one-cycle pulses
  input  wire logic                          bs_call_attempt,
  input  wire logic                          ms_answer,
  // status queries and settings
  input  wire logic                          cmd_valid,
  input  wire logic                          cmd_write,
  input  wire cssg_pkg::cssg_sel_type        cmd_sel,
  input  wire logic [`CSSG_REG_W-1:0]        cmd_wdata,
  input  wire logic                          clear_status,
  // answers and summary
  output logic                               rsp_valid,
  output logic [`CSSG_REG_W-1:0]             rsp_data,
  output logic                               summary_msg
);

  logic                     ringing;
  logic [`CSSG_REG_W-1:0]   cond_reg;       // see R1
  logic [`CSSG_REG_W-1:0]   cond_next;
  logic [`CSSG_REG_W-1:0]   cond_prev_reg;
  logic [`CSSG_REG_W-1:0]   rise_reg;
  logic [`CSSG_REG_W-1:0]   rise_next;
  logic [`CSSG_REG_W-1:0]   fall_reg;
  logic [`CSSG_REG_W-1:0]   fall_next;
  logic [`CSSG_REG_W-1:0]   event_reg;      // see R1
  logic [`CSSG_REG_W-1:0]   event_next;
  logic [`CSSG_REG_W-1:0]   event_set;
  logic [`CSSG_REG_W-1:0]   enable_reg;
  logic [`CSSG_REG_W-1:0]   enable_next;
  logic                     event_clear;
  logic                     rsp_valid_reg;
  logic                     rsp_valid_next;
  logic [`CSSG_REG_W-1:0]   rsp_data_reg;
  logic [`CSSG_REG_W-1:0]   rsp_data_next;
  logic                     summary_reg;
  logic                     summary_next;

  // ringing needs a small sequence of its own
  cssg_ring_tracker u_ring (
    .clk_sys         (clk_sys),
    .nrst            (nrst),
    .bs_call_attempt (bs_call_attempt),
    .ms_answer       (ms_answer),
    .ind_access      (ind_access),
    .ringing         (ringing)
  );

  // condition image; unused bits and bit 15 tied low
  always_comb
  begin
    cond_next                     = `CSSG_RST_ZERO; // see R3
    cond_next[`CSSG_BIT_ACTIVE]   = ind_active;     // see R11
    cond_next[`CSSG_BIT_REGISTER] = ind_register;   // see R10
    cond_next[`CSSG_BIT_AUTH]     = ind_auth;       // see R9
    cond_next[`CSSG_BIT_PAGE]     = ind_page;       // see R8
    cond_next[`CSSG_BIT_ACCESS]   = ind_access;     // see R7
    cond_next[`CSSG_BIT_CONNECT]  = ind_connect;    // see R6
    cond_next[`CSSG_BIT_RINGING]  = ringing;        // see R4 R5
  end

  // previous image kept only for edge detection
  always_ff @(posedge clk_sys)
  begin
    if (!nrst)
    begin
      cond_reg      <= `CSSG_RST_ZERO;
      cond_prev_reg <= `CSSG_RST_ZERO;
    end
    else
    begin
      cond_reg      <= cond_next;
      cond_prev_reg <= cond_reg;
    end
  end

  // writable filters and enable; writes to read-only registers dropped
  always_comb
  begin
    rise_next   = rise_reg;
    fall_next   = fall_reg;
    enable_next = enable_reg;
    if (cmd_valid && cmd_write)
    begin
      unique case (cmd_sel)
        cssg_pkg::CSSG_SEL_RISE:   rise_next   = cmd_wdata;
        cssg_pkg::CSSG_SEL_FALL:   fall_next   = cmd_wdata;
        cssg_pkg::CSSG_SEL_ENABLE: enable_next = cmd_wdata;
        default:                   ;
      endcase
    end
  end

  always_ff @(posedge clk_sys)
  begin
    if (!nrst)
    begin
      rise_reg   <= `CSSG_RST_RISE;
      fall_reg   <= `CSSG_RST_FALL;
      enable_reg <= `CSSG_RST_ENABLE;
    end
    else
    begin
      rise_reg   <= rise_next;
      fall_reg   <= fall_next;
      enable_reg <= enable_next;
    end
  end

  // one filter term per bit
  genvar gi;
  generate
    for (gi = 0; gi < `CSSG_REG_W; gi++)
    begin : g_edge
      assign event_set[gi] = (cond_reg[gi] & ~cond_prev_reg[gi] & rise_reg[gi]) |
                             (~cond_reg[gi] & cond_prev_reg[gi] & fall_reg[gi]); // see R13
    end
  endgenerate

  // a set in the clearing cycle survives, so no edge is lost
  always_comb
  begin
    event_clear = clear_status ||
                  (cmd_valid && !cmd_write && cmd_sel == cssg_pkg::CSSG_SEL_EVENT); // see R12
    event_next  = (event_clear ? `CSSG_RST_ZERO : event_reg) | event_set; // see R13
    // from next values so the summary lines up with the event register
    summary_next = |(event_next & enable_next); // see R14
  end

  always_ff @(posedge clk_sys)
  begin
    if (!nrst)
    begin
      event_reg   <= `CSSG_RST_ZERO;
      summary_reg <= 1'b0;
    end
    else
    begin
      event_reg   <= event_next;
      summary_reg <= summary_next;
    end
  end

  // query answer one cycle after the request; reads show pre-clear value
  always_comb
  begin
    rsp_valid_next = cmd_valid && !cmd_write;
    rsp_data_next  = `CSSG_RST_ZERO;
    if (cmd_valid && !cmd_write)
    begin
      unique case (cmd_sel)
        cssg_pkg::CSSG_SEL_COND:   rsp_data_next = cond_reg;
        cssg_pkg::CSSG_SEL_RISE:   rsp_data_next = rise_reg;
        cssg_pkg::CSSG_SEL_FALL:   rsp_data_next = fall_reg;
        cssg_pkg::CSSG_SEL_EVENT:  rsp_data_next = event_reg;
        cssg_pkg::CSSG_SEL_ENABLE: rsp_data_next = enable_reg;
        default:                   rsp_data_next = `CSSG_RST_ZERO;
      endcase
    end
  end

  always_ff @(posedge clk_sys)
  begin
    if (!nrst)
    begin
      rsp_valid_reg <= 1'b0;
      rsp_data_reg  <= `CSSG_RST_ZERO;
    end
    else
    begin
      rsp_valid_reg <= rsp_valid_next;
      rsp_data_reg  <= rsp_data_next;
    end
  end

  assign rsp_valid   = rsp_valid_reg;
  assign rsp_data    = rsp_data_reg;
  assign summary_msg = summary_reg; // see R2

  property p_unused_low;
    @(posedge clk_sys) disable iff (!nrst)
    (cond_reg & `CSSG_UNUSED_MASK) == `CSSG_RST_ZERO;
  endproperty
  a_unused_low: assert property (p_unused_low) // see R3
    else $error("unused condition bit set");

  property p_connect_mirror;
    @(posedge clk_sys) disable iff (!nrst)
    ##1 cond_reg[`CSSG_BIT_CONNECT] == $past(ind_connect);
  endproperty
  a_connect_mirror: assert property (p_connect_mirror) // see R6
    else $error("connect bit does not follow indicator");

  property p_access_mirror;
    @(posedge clk_sys) disable iff (!nrst)
    $rose(ind_access) |=> cond_reg[`CSSG_BIT_ACCESS];
  endproperty
  a_access_mirror: assert property (p_access_mirror) // see R7
    else $error("access bit missed indicator");

  property p_page_mirror;
    @(posedge clk_sys) disable iff (!nrst)
    !ind_page |=> !cond_reg[`CSSG_BIT_PAGE];
  endproperty
  a_page_mirror: assert property (p_page_mirror) // see R8
    else $error("page bit set without indicator");

  property p_low_bits;
    @(posedge clk_sys) disable iff (!nrst)
    ##1 cond_reg[2:0] == {$past(ind_auth), $past(ind_register), $past(ind_active)};
  endproperty
  a_low_bits: assert property (p_low_bits) // see R9 R10 R11
    else $error("auth, register or active bit wrong");

  property p_read_clears;
    @(posedge clk_sys) disable iff (!nrst)
    (cmd_valid && !cmd_write && cmd_sel == cssg_pkg::CSSG_SEL_EVENT) || clear_status
      |=> event_reg == $past(event_set);
  endproperty
  a_read_clears: assert property (p_read_clears) // see R12
    else $error("event register not cleared");

  property p_event_latch;
    @(posedge clk_sys) disable iff (!nrst)
    (event_set != `CSSG_RST_ZERO) |=> (event_reg & $past(event_set)) == $past(event_set);
  endproperty
  a_event_latch: assert property (p_event_latch) // see R13
    else $error("filtered edge not latched");

  property p_event_sticky;
    @(posedge clk_sys) disable iff (!nrst)
    !clear_status && !cmd_valid ##1 1'b1 |-> (event_reg & $past(event_reg)) == $past(event_reg);
  endproperty
  a_event_sticky: assert property (p_event_sticky) // see R13
    else $error("event bit dropped without a clear");

  property p_summary;
    @(posedge clk_sys) disable iff (!nrst)
    summary_msg == |(event_reg & enable_reg);
  endproperty
  a_summary: assert property (p_summary) // see R14
    else $error("summary disagrees with event and enable");

  property p_read_answer;
    @(posedge clk_sys) disable iff (!nrst)
    cmd_valid && !cmd_write && cmd_sel == cssg_pkg::CSSG_SEL_RISE
      |=> rsp_valid && rsp_data == $past(rise_reg);
  endproperty
  a_read_answer: assert property (p_read_answer) // see R1 R2
    else $error("filter query answered wrongly");

  // ringing bit lags the tracker by one register stage
  property p_ringing_bit;
    @(posedge clk_sys) disable iff (!nrst)
    ##1 cond_reg[`CSSG_BIT_RINGING] == $past(ringing);
  endproperty
  a_ringing_bit: assert property (p_ringing_bit) // see R4 R5
    else $error("ringing bit does not follow tracker");

  // a new event bit needs a filtered edge behind it
  property p_no_spurious_event;
    @(posedge clk_sys) disable iff (!nrst)
    ##1 (event_reg & ~$past(event_reg) & ~$past(event_set)) == `CSSG_RST_ZERO;
  endproperty
  a_no_spurious_event: assert property (p_no_spurious_event) // see R13
    else $error("event bit set without a filtered edge");

  // a setting lands on the next edge, ready for the summary
  property p_enable_write;
    @(posedge clk_sys) disable iff (!nrst)
    cmd_valid && cmd_write && cmd_sel == cssg_pkg::CSSG_SEL_ENABLE
      |=> enable_reg == $past(cmd_wdata);
  endproperty
  a_enable_write: assert property (p_enable_write) // see R2
    else $error("enable setting not stored");

  // answer port quiet unless a query was taken
  property p_rsp_idle;
    @(posedge clk_sys) disable iff (!nrst)
    !(cmd_valid && !cmd_write) |=> !rsp_valid && rsp_data == `CSSG_RST_ZERO;
  endproperty
  a_rsp_idle: assert property (p_rsp_idle) // see R2
    else $error("answer shown without a query");

endmodule : cssg_status_group

`default_nettype wire

// [sim/tb_cssg_status_group.sv]
`include "cssg_defines.svh"
`default_nettype none

module tb_cssg_status_group;
  timeunit 1ns;
  timeprecision 100ps;

  logic                   clk_sys;
  logic                   nrst;
  logic [5:0]             ind;
  logic                   bs_call_attempt;
  logic                   ms_answer;
  logic                   cmd_valid;
  logic                   cmd_write;
  cssg_pkg::cssg_sel_type cmd_sel;
  logic [`CSSG_REG_W-1:0] cmd_wdata;
  logic                   clear_status;
  logic                   rsp_valid;
  logic [`CSSG_REG_W-1:0] rsp_data;
  logic                   summary_msg;
  int                     mismatches;
  int                     n_compared;
  // reference model state
  logic [15:0]            m_cond, m_cond_d, m_rise, m_fall, m_evt, m_ena, m_rd, m_edge;
  logic                   m_rv, m_sum, m_ring, m_clr;
  logic                   m_live = 1'b0;
  int                     m_step;

  cssg_status_group cssg_status_group_inst (
    .clk_sys         (clk_sys),
    .nrst            (nrst),
    .ind_active      (ind[0]),
    .ind_register    (ind[1]),
    .ind_auth        (ind[2]),
    .ind_page        (ind[3]),
    .ind_access      (ind[4]),
    .ind_connect     (ind[5]),
    .bs_call_attempt (bs_call_attempt),
    .ms_answer       (ms_answer),
    .cmd_valid       (cmd_valid),
    .cmd_write       (cmd_write),
    .cmd_sel         (cmd_sel),
    .cmd_wdata       (cmd_wdata),
    .clear_status    (clear_status),
    .rsp_valid       (rsp_valid),
    .rsp_data        (rsp_data),
    .summary_msg     (summary_msg)
  );

  // 125 MHz system clock
  initial clk_sys = 1'b0;
  always #4 clk_sys = ~clk_sys;

  // cycle model, fed only by bench inputs, so no race with the design
  always @(posedge clk_sys)
  begin
    if (!nrst)
    begin
      m_cond   = `CSSG_RST_ZERO;
      m_cond_d = `CSSG_RST_ZERO;
      m_rise   = `CSSG_RST_RISE;
      m_fall   = `CSSG_RST_FALL;
      m_evt    = `CSSG_RST_ZERO;
      m_ena    = `CSSG_RST_ENABLE;
      m_rv     = 1'b0;
      m_rd     = 16'h0000;
      m_sum    = 1'b0;
      m_ring   = 1'b0;
      m_step   = 0;
      m_live   = 1'b1;
    end
    else
    begin
      m_edge = (m_cond & ~m_cond_d & m_rise) | (~m_cond & m_cond_d & m_fall);
      m_rv   = cmd_valid & ~cmd_write;
      case (cmd_sel)
        cssg_pkg::CSSG_SEL_COND:   m_rd = m_cond;
        cssg_pkg::CSSG_SEL_RISE:   m_rd = m_rise;
        cssg_pkg::CSSG_SEL_FALL:   m_rd = m_fall;
        cssg_pkg::CSSG_SEL_EVENT:  m_rd = m_evt;
        cssg_pkg::CSSG_SEL_ENABLE: m_rd = m_ena;
        default:                   m_rd = 16'h0000;
      endcase
      if (!m_rv) m_rd = 16'h0000;
      m_clr = clear_status | (m_rv & (cmd_sel == cssg_pkg::CSSG_SEL_EVENT));
      m_evt = (m_clr ? 16'h0000 : m_evt) | m_edge;
      if (cmd_valid && cmd_write && cmd_sel == cssg_pkg::CSSG_SEL_RISE) m_rise = cmd_wdata;
      if (cmd_valid && cmd_write && cmd_sel == cssg_pkg::CSSG_SEL_FALL) m_fall = cmd_wdata;
      if (cmd_valid && cmd_write && cmd_sel == cssg_pkg::CSSG_SEL_ENABLE) m_ena = cmd_wdata;
      m_sum    = |(m_evt & m_ena);
      m_cond_d = m_cond;
      m_cond   = {9'h000, m_ring, ind};
      // ringing: attempt, access seen high, access gone low; answer cancels any step
      if (ms_answer) m_step = 0;
      else if (m_step == 0 && bs_call_attempt) m_step = 1;
      else if (m_step == 1 && ind[4]) m_step = 2;
      else if (m_step == 2 && !ind[4]) m_step = 3;
      m_ring = (m_step == 3);
    end
  end

  // outputs settle well before the falling edge
  always @(negedge clk_sys)
  begin
    if (m_live)
    begin
      check("rsp_valid", {15'h0000, rsp_valid}, {15'h0000, m_rv});
      check("rsp_data", rsp_data, m_rd);
      check("summary_msg", {15'h0000, summary_msg}, {15'h0000, m_sum});
    end
  end

  task automatic check(input string what, input logic [15:0] seen, input logic [15:0] exp);
    n_compared++;
    if (seen !== exp)
    begin
      mismatches++;
      $display("BAD %s expected %h seen %h", what, exp, seen);
    end
  endtask : check

  task automatic tick(input int n);
    repeat (n) @(posedge clk_sys);
    #1;
  endtask : tick

  // leading tick keeps a strobe from being lowered and raised in one step
  task automatic cmd(input logic wr, input int sel, input logic [15:0] data);
    tick(1);
    cmd_valid = 1'b1;
    cmd_write = wr;
    cmd_sel   = cssg_pkg::cssg_sel_type'(sel[2:0]);
    cmd_wdata = data;
    tick(1);
    cmd_valid = 1'b0;
  endtask : cmd

  task automatic query(input int sel, input logic [15:0] exp);
    cmd(1'b0, sel, 16'h0000);
    check("query", rsp_data, exp);
  endtask : query

  task automatic do_reset;
    nrst = 1'b0;
    tick(3);
    nrst = 1'b1;
  endtask : do_reset

  task automatic wrap_up;
    $display("compared %0d mismatches %0d", n_compared, mismatches);
    if (mismatches == 0 && n_compared > 0)
      $display("All checks passed");
    else
      $display("Checks failed");
    $finish;
  endtask : wrap_up

  // the whole run needs about 2110 cycles
  initial
  begin
    #(8 * 10000);
    mismatches++;
    $display("watchdog expired");
    wrap_up();
  end

  initial
  begin
    void'($urandom(32'hcc4b_7a15));
    {mismatches, n_compared} = '0;
    {ind, bs_call_attempt, ms_answer, cmd_valid, cmd_write, clear_status} = '0;
    cmd_sel   = cssg_pkg::CSSG_SEL_COND;
    cmd_wdata = 16'h0000;
    do_reset();
    for (int s = 0; s < 8; s++) query(s, s == 1 ? `CSSG_RST_RISE : 16'h0000);
    $display("test reset values done");
    // one indicator at a time lands on its own bit
    for (int b = 0; b < 6; b++)
    begin
      ind = 6'(1 << b);
      tick(2);
      query(0, 16'(1 << b));
    end
    ind = 6'h00;
    tick(3);
    query(3, 16'h003F);
    query(3, 16'h0000);
    $display("test condition bits done");
    // falling edge only, gated into the summary, then cleared
    cmd(1'b1, 2, 16'h0008);
    cmd(1'b1, 1, 16'h0000);
    cmd(1'b1, 4, 16'h0008);
    ind = 6'h08;
    tick(4);
    ind = 6'h00;
    tick(3);
    check("summary", {15'h0000, summary_msg}, 16'h0001);
    clear_status = 1'b1;
    tick(1);
    clear_status = 1'b0;
    tick(1);
    check("summary", {15'h0000, summary_msg}, 16'h0000);
    cmd(1'b1, 0, 16'hFFFF);
    cmd(1'b1, 3, 16'hFFFF);
    query(0, 16'h0000);
    query(3, 16'h0000);
    $display("test filters and summary done");
    // base-originated call passes access, rings, then is answered
    cmd(1'b1, 1, 16'h0040);
    tick(1);
    bs_call_attempt = 1'b1;
    tick(1);
    bs_call_attempt = 1'b0;
    ind = 6'h10;
    tick(1);
    ind = 6'h00;
    tick(3);
    query(0, 16'h0040);
    query(3, 16'h0040);
    ms_answer = 1'b1;
    tick(1);
    ms_answer = 1'b0;
    tick(2);
    query(0, 16'h0000);
    $display("test ringing done");
    // random traffic, back to back commands, against the model
    tick(1);
    for (int i = 0; i < 2000; i++)
    begin
      if ($urandom % 4 == 0) ind = 6'($urandom);
      cmd_valid    = 1'($urandom % 2);
      cmd_write    = 1'($urandom % 2);
      cmd_sel      = cssg_pkg::cssg_sel_type'(3'($urandom % 8));
      cmd_wdata    = 16'($urandom);
      clear_status = ($urandom % 16 == 0);
      bs_call_attempt = ($urandom % 16 == 0);
      ms_answer    = ($urandom % 32 == 0);
      tick(1);
    end
    {cmd_valid, clear_status, ind, bs_call_attempt, ms_answer} = '0;
    $display("test random traffic done");
    // second reset in mid-run restores every register
    do_reset();
    for (int s = 0; s < 8; s++) query(s, s == 1 ? `CSSG_RST_RISE : 16'h0000);
    $display("test second reset done");
    wrap_up();
  end
endmodule : tb_cssg_status_group

`default_nettype wire
